// [common/qup_cfg.svh]
// constants for the quad serial pin-level block: offsets, fields, reset values, timing
// assumes inclusion from the package, the transceiver module and the sim checker and bench
`ifndef QUP_CFG_SVH
`define QUP_CFG_SVH

// -------------------------------------------------------------
// geometry
// -------------------------------------------------------------
`define QUP_NCH 4
`define QUP_FIFO_DEPTH 16
`define QUP_DATA_W 8

// -------------------------------------------------------------
// per-channel register offsets, addr[2:0]; addr[4:3] picks channel
// -------------------------------------------------------------
`define QUP_REG_DATA 3'h0
`define QUP_REG_STATUS 3'h1
`define QUP_REG_CTRL 3'h2

// -------------------------------------------------------------
// field positions and reset values
// -------------------------------------------------------------
`define QUP_ST_RX_READY 0
`define QUP_ST_TX_BUSY 1
`define QUP_ST_OVERRUN 2
`define QUP_CTRL_LOOP 0
`define QUP_CTRL_TX_EN 1
`define QUP_CTRL_RESET 8'h02

// -------------------------------------------------------------
// timing: 100 MHz clock, 16x oversampling of each bit
// -------------------------------------------------------------
`define QUP_CLK_HZ 100000000
`define QUP_BAUD 115200
`define QUP_OVS 16
`define QUP_BAUD_DIV (`QUP_CLK_HZ / (`QUP_BAUD * `QUP_OVS))
`define QUP_OVS_LAST 4'hf
`define QUP_OVS_MID 4'h7
`define QUP_BIT_LAST 3'h7

`endif

// [common/qup_pkg.sv]
// types shared by the quad serial pin-level block
// assumes qup_cfg.svh is on the include path
`include "qup_cfg.svh"
package qup_pkg;

   // receiver and transmitter sequencing
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} qup_rx_state_t;
   typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} qup_tx_state_t;

   typedef struct packed {
      qup_rx_state_t state;
      logic [3:0] cnt;
      logic [2:0] bits;
      logic [7:0] shift;
   } qup_rx_t;

   typedef struct packed {
      qup_tx_state_t state;
      logic [3:0] cnt;
      logic [2:0] bits;
      logic [7:0] shift;
      logic line;
   } qup_tx_t;

   // one decoded host access, valid for a single cycle
   typedef struct packed {
      logic rd;
      logic wr;
      logic [4:0] addr;
      logic [7:0] wdata;
   } qup_bus_req_t;

endpackage : qup_pkg

// [hdl/qup_fifo.sv]
// first-in first-out buffer with valid/ready on both sides
// assumes one clock and an asynchronous active-high reset
`timescale 1ns/1ps
module qup_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_ptr_reg, wr_ptr_next, rd_ptr_reg, rd_ptr_next;
   logic [AW:0] count_reg, count_next;
   logic push, pop;

   // -------------------------------------------------------------
   // flags and pointer arithmetic
   // -------------------------------------------------------------
   // count is one bit wider than a pointer, so full must be compared at that width
   assign in_ready = (count_reg != (AW+1)'(DEPTH));
   assign out_valid = (count_reg != '0);
   assign push = in_valid & in_ready;
   assign pop = out_ready & out_valid;
   assign out_data = mem_reg[rd_ptr_reg]; // storage is flops, so this is a register read

   // next pointers; wrap is explicit so depth need not be a power of two
   always_comb begin
      wr_ptr_next = wr_ptr_reg;
      rd_ptr_next = rd_ptr_reg;
      count_next = count_reg;
      if (push) begin
         wr_ptr_next = (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
         rd_ptr_next = (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
         count_next = count_reg + 1'b1;
      end else if (pop && !push) begin
         count_next = count_reg - 1'b1;
      end
   end

   // pointer registers
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_next;
         rd_ptr_reg <= rd_ptr_next;
         count_reg <= count_next;
      end
   end

   // storage has no reset; only written slots are ever read
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end

endmodule : qup_fifo

// [hdl/qup_pin_io.sv]
// four-channel serial transceiver: host bus, serial pins, loop-back, combined receive ready
// assumes pins synchronous to clk_sys, 8N1 framing, bit rate set by BAUD_DIV
//
// What this block does
// RL1 - direction strobe high on a selected access returns the addressed register
// RL2 - direction strobe low on a selected access stores bus data into addressed register
// RL3 - combined direction strobe obeyed only in 68 mode; other mode uses read/write strobes
// RL4 - remote party holds each serial input high in reset, idle, or disabled
// RL5 - loop-back ignores the serial input pin and feeds own transmit data to receiver
// RL6 - loop-back disables the external transmit pin; data only reaches internal receiver
// RL7 - transmit pin is high in reset and when idle; disabling the transmitter stops new frames but lets a started frame finish
// RL8 - combined receive ready is the active-low OR of all four channel ready conditions
// RL9 - combined receive ready low when any channel holds a received character
// RL10 - combined receive ready returns high once no channel holds any character
// RL11 - each channel's receive status is readable through its own register
// RL12 - loop-back selectable per channel and leaves other channels' pins untouched
`timescale 1ns/1ps
`include "qup_cfg.svh"
module qup_pin_io
   import qup_pkg::*;
#(
   parameter int NCH = `QUP_NCH,
   parameter int FIFO_DEPTH = `QUP_FIFO_DEPTH,
   parameter int BAUD_DIV = `QUP_BAUD_DIV
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // host bus
   input wire logic mode68,
   input wire logic cs_n,
   input wire logic [4:0] addr,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata,
   input wire logic rd_wr,
   input wire logic strobe_n,
   input wire logic rd_n,
   input wire logic wr_n,
   // serial pins
   input wire logic [NCH-1:0] serial_in_channel,
   output logic [NCH-1:0] serial_out_channel,
   // receive ready
   output logic [NCH-1:0] channel_receive_ready_n,
   output logic combined_receive_ready_n
);

   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   // true when the access targets register r of channel ch
   function automatic logic hits(input logic [4:0] a, input int ch, input logic [2:0] r);
      hits = (a[4:3] == 2'(ch)) && (a[2:0] == r);
   endfunction : hits

   // -------------------------------------------------------------
   // host access decode
   // -------------------------------------------------------------
   logic sel, sel_prev_reg, sel_prev_next;
   logic acc_rd, acc_wr;
   qup_bus_req_t req;

   // one request per select assertion, taken on its leading edge
   always_comb begin
      if (mode68) begin
         sel = ~cs_n & ~strobe_n;
         acc_rd = rd_wr; // see RL1
         acc_wr = ~rd_wr; // see RL2
      end else begin
         sel = ~cs_n & (~rd_n | ~wr_n); // direction strobe ignored here, see RL3
         acc_rd = ~rd_n;
         acc_wr = rd_n & ~wr_n;
      end
      sel_prev_next = sel;
      req.rd = sel & ~sel_prev_reg & acc_rd;
      req.wr = sel & ~sel_prev_reg & acc_wr;
      req.addr = addr;
      req.wdata = wdata;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sel_prev_reg <= 1'b0;
      end else begin
         sel_prev_reg <= sel_prev_next;
      end
   end

   // -------------------------------------------------------------
   // oversampling tick divider
   // -------------------------------------------------------------
   localparam int DW = $clog2(BAUD_DIV + 1);
   logic [DW-1:0] div_reg, div_next;
   logic tick;

   always_comb begin
      tick = (div_reg == DW'(BAUD_DIV - 1));
      div_next = tick ? '0 : div_reg + 1'b1;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_next;
      end
   end

   // -------------------------------------------------------------
   // channels
   // -------------------------------------------------------------
   logic [7:0] rd_mux [NCH];
   logic [NCH-1:0] rx_ready;

   for (genvar c = 0; c < NCH; c++) begin : g_ch
      qup_rx_t rx_reg, rx_next;
      qup_tx_t tx_reg, tx_next;
      logic [7:0] ctrl_reg, ctrl_next;
      logic [7:0] thr_reg, thr_next;
      logic thr_full_reg, thr_full_next;
      logic ovr_reg, ovr_next;
      logic rx_line, push, fifo_in_ready, fifo_out_valid, pop, tx_busy;
      logic [7:0] head;

      // loop-back routes this channel's own transmit line, see RL5 RL12
      // outside loop-back the remote party idles the pin high, see RL4
      assign rx_line = ctrl_reg[`QUP_CTRL_LOOP] ? tx_reg.line : serial_in_channel[c];
      // pin held at idle high in loop-back, so nothing leaves the device, see RL6 RL12
      assign serial_out_channel[c] = ctrl_reg[`QUP_CTRL_LOOP] ? 1'b1 : tx_reg.line; // see RL7
      assign pop = req.rd && hits(req.addr, c, `QUP_REG_DATA);
      assign tx_busy = thr_full_reg | (tx_reg.state != TX_IDLE);
      assign rx_ready[c] = fifo_out_valid;

      // receive holding register sits at the fifo head
      qup_fifo #(
         .WIDTH(`QUP_DATA_W),
         .DEPTH(FIFO_DEPTH)
      ) u_rx_fifo (
         .clk_sys(clk_sys),
         .rst(rst),
         .in_valid(push),
         .in_ready(fifo_in_ready),
         .in_data(rx_reg.shift),
         .out_valid(fifo_out_valid),
         .out_ready(pop),
         .out_data(head)
      );

      // receiver: start check at mid bit, then one sample per bit time
      always_comb begin
         rx_next = rx_reg;
         push = 1'b0;
         if (tick) begin
            rx_next.cnt = rx_reg.cnt + 1'b1;
            unique case (rx_reg.state)
               RX_IDLE: begin
                  rx_next.cnt = '0;
                  if (!rx_line) begin
                     rx_next.state = RX_START;
                  end
               end
               RX_START: begin
                  if (rx_reg.cnt == `QUP_OVS_MID) begin
                     rx_next.cnt = '0;
                     rx_next.bits = '0;
                     rx_next.state = rx_line ? RX_IDLE : RX_DATA; // glitch rejected
                  end
               end
               RX_DATA: begin
                  if (rx_reg.cnt == `QUP_OVS_LAST) begin
                     rx_next.shift = {rx_line, rx_reg.shift[7:1]};
                     rx_next.bits = rx_reg.bits + 1'b1;
                     if (rx_reg.bits == `QUP_BIT_LAST) begin
                        rx_next.state = RX_STOP;
                     end
                  end
               end
               RX_STOP: begin
                  if (rx_reg.cnt == `QUP_OVS_LAST) begin
                     push = rx_line; // framing errors are dropped
                     rx_next.state = RX_IDLE;
                  end
               end
            endcase
         end
      end

      // transmitter; a disabled transmitter never leaves idle, line stays high
      always_comb begin
         tx_next = tx_reg;
         thr_next = thr_reg;
         thr_full_next = thr_full_reg;
         if (tick) begin
            tx_next.cnt = tx_reg.cnt + 1'b1;
            unique case (tx_reg.state)
               TX_IDLE: begin
                  tx_next.cnt = '0;
                  tx_next.line = 1'b1; // see RL7
                  if (thr_full_reg && ctrl_reg[`QUP_CTRL_TX_EN]) begin
                     tx_next.shift = thr_reg;
                     thr_full_next = 1'b0;
                     tx_next.line = 1'b0;
                     tx_next.state = TX_START;
                  end
               end
               TX_START: begin
                  if (tx_reg.cnt == `QUP_OVS_LAST) begin
                     tx_next.bits = '0;
                     tx_next.line = tx_reg.shift[0];
                     tx_next.state = TX_DATA;
                  end
               end
               TX_DATA: begin
                  if (tx_reg.cnt == `QUP_OVS_LAST) begin
                     tx_next.shift = {1'b1, tx_reg.shift[7:1]};
                     tx_next.bits = tx_reg.bits + 1'b1;
                     tx_next.line = tx_reg.shift[1];
                     if (tx_reg.bits == `QUP_BIT_LAST) begin
                        tx_next.line = 1'b1;
                        tx_next.state = TX_STOP;
                     end
                  end
               end
               TX_STOP: begin
                  if (tx_reg.cnt == `QUP_OVS_LAST) begin
                     tx_next.state = TX_IDLE;
                  end
               end
            endcase
         end
         // a host write overrides a same-cycle load, so no character is lost
         if (req.wr && hits(req.addr, c, `QUP_REG_DATA)) begin // see RL2
            thr_next = req.wdata;
            thr_full_next = 1'b1;
         end
      end

      // control and overrun; overrun set beats the read that clears it
      always_comb begin
         ctrl_next = ctrl_reg;
         ovr_next = ovr_reg;
         if (req.wr && hits(req.addr, c, `QUP_REG_CTRL)) begin // see RL2 RL12
            ctrl_next = req.wdata;
         end
         if (req.rd && hits(req.addr, c, `QUP_REG_STATUS)) begin
            ovr_next = 1'b0;
         end
         if (push && !fifo_in_ready) begin
            ovr_next = 1'b1;
         end
      end

      // read value for this channel, zero when unmapped
      always_comb begin
         rd_mux[c] = 8'h00;
         if (req.addr[4:3] == 2'(c)) begin
            unique case (req.addr[2:0])
               `QUP_REG_DATA: rd_mux[c] = fifo_out_valid ? head : 8'h00;
               `QUP_REG_STATUS: begin // see RL11
                  rd_mux[c][`QUP_ST_RX_READY] = fifo_out_valid;
                  rd_mux[c][`QUP_ST_TX_BUSY] = tx_busy;
                  rd_mux[c][`QUP_ST_OVERRUN] = ovr_reg;
               end
               `QUP_REG_CTRL: rd_mux[c] = ctrl_reg;
               default: rd_mux[c] = 8'h00;
            endcase
         end
      end

      always_ff @(posedge clk_sys or posedge rst) begin
         if (rst) begin
            rx_reg <= '{state: RX_IDLE, cnt: 4'h0, bits: 3'h0, shift: 8'h00};
            tx_reg <= '{state: TX_IDLE, cnt: 4'h0, bits: 3'h0, shift: 8'h00, line: 1'b1};
            ctrl_reg <= `QUP_CTRL_RESET;
            thr_reg <= 8'h00;
            thr_full_reg <= 1'b0;
            ovr_reg <= 1'b0;
         end else begin
            rx_reg <= rx_next;
            tx_reg <= tx_next;
            ctrl_reg <= ctrl_next;
            thr_reg <= thr_next;
            thr_full_reg <= thr_full_next;
            ovr_reg <= ovr_next;
         end
      end
   end

   // -------------------------------------------------------------
   // read data and ready outputs
   // -------------------------------------------------------------
   logic [7:0] rdata_reg, rdata_next;
   logic comb_rdy_n_reg, comb_rdy_n_next;
   logic [NCH-1:0] ch_rdy_n_reg, ch_rdy_n_next;

   // read data held until the next read; ready flags registered with fifo state
   always_comb begin
      rdata_next = rdata_reg;
      if (req.rd) begin
         rdata_next = 8'h00;
         for (int c = 0; c < NCH; c++) begin
            rdata_next = rdata_next | rd_mux[c]; // see RL1
         end
      end
      ch_rdy_n_next = ~rx_ready;
      comb_rdy_n_next = ~(|rx_ready); // see RL8 RL9 RL10
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rdata_reg <= 8'h00;
         comb_rdy_n_reg <= 1'b1;
         ch_rdy_n_reg <= '1;
      end else begin
         rdata_reg <= rdata_next;
         comb_rdy_n_reg <= comb_rdy_n_next;
         ch_rdy_n_reg <= ch_rdy_n_next;
      end
   end

   assign rdata = rdata_reg;
   assign combined_receive_ready_n = comb_rdy_n_reg;
   assign channel_receive_ready_n = ch_rdy_n_reg;

endmodule : qup_pin_io

// [sim/qup_pin_io_checker.sv]
// concurrent checks on the ports of the quad serial pin block
// assumes binding to qup_pin_io; channel 0 line framing is watched
`timescale 1ns/1ps
`include "qup_cfg.svh"
module qup_pin_io_checker
   import qup_pkg::*;
#(
   parameter int NCH = 4,
   parameter int BAUD_DIV = 1
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // host bus
   input wire logic mode68,
   input wire logic cs_n,
   input wire logic [4:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic rd_wr,
   input wire logic strobe_n,
   input wire logic rd_n,
   input wire logic wr_n,
   // serial and ready
   input wire logic [NCH-1:0] serial_out_channel,
   input wire logic [NCH-1:0] channel_receive_ready_n,
   input wire logic combined_receive_ready_n
);
   localparam int BIT = 16 * BAUD_DIV;
   logic sel, is_rd, tk;
   logic sel_reg, sel_next, rtk_reg, rtk_next;
   logic [NCH-1:0] frc_reg, frc_next;
   logic [11:0] lo_reg, lo_next;
   // --------
   // helper state
   // --------
   // take decode on the leading edge of select; frc marks lines forced idle
   always_comb begin
      sel = mode68 ? (!cs_n && !strobe_n) : (!cs_n && (!rd_n || !wr_n));
      is_rd = mode68 ? rd_wr : !rd_n;
      tk = sel && !sel_reg;
      sel_next = sel;
      rtk_next = tk && is_rd;
      frc_next = frc_reg;
      if (tk && !is_rd && addr[2:0] == `QUP_REG_CTRL) begin
         frc_next[addr[4:3]] = wdata[`QUP_CTRL_LOOP] || !wdata[`QUP_CTRL_TX_EN];
      end
      lo_next = serial_out_channel[0] ? 12'h000 : lo_reg + 12'h001;
   end
   // registers only
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sel_reg <= 1'b0;
         rtk_reg <= 1'b0;
         frc_reg <= '0;
         lo_reg <= 12'h000;
      end else begin
         sel_reg <= sel_next;
         rtk_reg <= rtk_next;
         frc_reg <= frc_next;
         lo_reg <= lo_next;
      end
   end
   // --------
   // properties
   // --------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   // both outputs are registered in the same cycle from the fifo state; three cycles are only margin
   sequence s_all_empty;
      (&channel_receive_ready_n)[*3];
   endsequence
   sequence s_any_held;
      (!(&channel_receive_ready_n))[*3];
   endsequence
   a_reset_idle: assert property (
      $fell(rst) |-> (&serial_out_channel) && combined_receive_ready_n && rdata == 8'h00)
      else $error("outputs not idle after reset");
   a_comb_high: assert property (s_all_empty |-> combined_receive_ready_n)
      else $error("combined ready low with all channels empty");
   a_comb_low: assert property (s_any_held |-> !combined_receive_ready_n)
      else $error("combined ready high with a channel holding data");
   a_rdata_cause: assert property (!$stable(rdata) |-> rtk_reg)
      else $error("read data changed without a read");
   a_unmapped_zero: assert property (
      rtk_reg && $past(addr[2:0]) > `QUP_REG_CTRL |-> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_forced_high: assert property (
      (frc_reg & $past(frc_reg) & ~serial_out_channel) == '0)
      else $error("forced line not high");
   a_bit_length: assert property ($rose(serial_out_channel[0]) |-> lo_reg % BIT == 0)
      else $error("low run not whole bits");
   a_frame_max: assert property (lo_reg <= 9 * BIT)
      else $error("line low longer than a frame");
endmodule : qup_pin_io_checker

bind qup_pin_io qup_pin_io_checker #(.NCH(NCH), .BAUD_DIV(BAUD_DIV)) u_chk (
   .clk_sys(clk_sys), .rst(rst), .mode68(mode68), .cs_n(cs_n), .addr(addr),
   .wdata(wdata), .rdata(rdata), .rd_wr(rd_wr), .strobe_n(strobe_n), .rd_n(rd_n),
   .wr_n(wr_n), .serial_out_channel(serial_out_channel),
   .channel_receive_ready_n(channel_receive_ready_n),
   .combined_receive_ready_n(combined_receive_ready_n)
);

// [sim/qup_pin_io_tb_top.sv]
// self-checking bench for the quad serial pin block
// assumes the remote model on the serial inputs and the bound checker
`timescale 1ns/1ps
`include "qup_cfg.svh"
module qup_pin_io_tb_top;
   localparam int BIT = 16;
   logic clk_sys, rst, mode68, cs_n, rd_wr, strobe_n, rd_n, wr_n, cmb_n;
   logic [4:0] addr;
   logic [7:0] wdata, rdata;
   logic [3:0] sin, sout, rdy_n;
   int bad_count, tests_run, cyc;
   // short divider keeps a frame at 160 clocks
   qup_pin_io #(.BAUD_DIV(1)) uut (
      .clk_sys(clk_sys), .rst(rst), .mode68(mode68), .cs_n(cs_n), .addr(addr),
      .wdata(wdata), .rdata(rdata), .rd_wr(rd_wr), .strobe_n(strobe_n),
      .rd_n(rd_n), .wr_n(wr_n), .serial_in_channel(sin), .serial_out_channel(sout),
      .channel_receive_ready_n(rdy_n), .combined_receive_ready_n(cmb_n)
   );
   qup_remote_model #(.BIT(BIT)) rm (.clk_sys(clk_sys), .line(sin));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // hang guard, well above the roughly 800 cycles needed
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         end_of_test();
      end
   end
   // --------
   // common tasks
   // --------
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_of_test
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
      tests_run++;
      if (s !== e) begin
         $display("MISMATCH %s expected %h seen %h", n, e, s);
         bad_count++;
      end
   endtask : chk
   task automatic idle(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : idle
   // one access; rd_wr is set opposite in mode 0 since it must be ignored
   task automatic acc(input logic rd, input logic [4:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      cs_n = 1'b0;
      rd_wr = mode68 ? rd : !rd;
      strobe_n = !mode68;
      rd_n = mode68 || !rd;
      wr_n = mode68 || rd;
      @(negedge clk_sys);
      cs_n = 1'b1;
      strobe_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      @(negedge clk_sys);
   endtask : acc
   task automatic rdchk(input string n, input logic [4:0] a, input logic [7:0] e);
      acc(1'b1, a, 8'h00);
      chk(n, e, rdata);
   endtask : rdchk
   // --------
   // scenarios
   // --------
   task automatic t_reset();
      chk("tx idle", 8'h0f, {4'h0, sout});
      chk("ready idle", 8'h1f, {3'h0, cmb_n, rdy_n});
      for (int c = 0; c < 4; c++) begin
         rdchk("ctrl", {c[1:0], `QUP_REG_CTRL}, `QUP_CTRL_RESET);
      end
   endtask : t_reset
   // two channels fill, drained one at a time
   task automatic t_rx();
      fork
         rm.send(1, 8'ha5);
         rm.send(3, 8'h3c);
      join
      idle(4);
      chk("chan ready", 8'h05, {4'h0, rdy_n});
      chk("comb low", 8'h00, {7'h0, cmb_n});
      acc(1'b1, {2'd1, `QUP_REG_STATUS}, 8'h00);
      chk("status rx", 8'h01, {7'h0, rdata[`QUP_ST_RX_READY]});
      rdchk("data ch1", {2'd1, `QUP_REG_DATA}, 8'ha5);
      idle(4);
      chk("comb one left", 8'h00, {7'h0, cmb_n});
      rdchk("data ch3", {2'd3, `QUP_REG_DATA}, 8'h3c);
      idle(4);
      chk("comb empty", 8'h01, {7'h0, cmb_n});
   endtask : t_rx
   // mode 0 write, frame sampled mid-bit
   task automatic t_tx();
      int n;
      logic [9:0] f;
      f = {1'b1, 8'h96, 1'b0};
      mode68 = 1'b0;
      acc(1'b0, {2'd0, `QUP_REG_DATA}, 8'h96);
      n = 0;
      while (sout[0] === 1'b1 && n < 100) begin
         @(negedge clk_sys);
         n++;
      end
      idle(BIT / 2);
      for (int i = 0; i < 10; i++) begin
         chk("tx bit", {7'h0, f[i]}, {7'h0, sout[0]});
         idle(BIT);
      end
      mode68 = 1'b1;
   endtask : t_tx
   // loop on channel 2 while its pin and channel 1 carry traffic
   task automatic t_loop();
      logic low;
      low = 1'b0;
      acc(1'b0, {2'd2, `QUP_REG_CTRL}, 8'h03);
      fork
         rm.send(2, 8'h55);
         rm.send(1, 8'hc3);
         acc(1'b0, {2'd2, `QUP_REG_DATA}, 8'h81);
         repeat (12 * BIT) begin
            @(negedge clk_sys);
            low = low | !sout[2];
         end
      join
      chk("loop pin", 8'h00, {7'h0, low});
      rdchk("loop data", {2'd2, `QUP_REG_DATA}, 8'h81);
      rdchk("pin ignored", {2'd2, `QUP_REG_DATA}, 8'h00);
      rdchk("other chan", {2'd1, `QUP_REG_DATA}, 8'hc3);
      acc(1'b0, {2'd2, `QUP_REG_CTRL}, `QUP_CTRL_RESET);
   endtask : t_loop
   // disabled transmitter keeps its byte and its pin high, then sends once enabled
   task automatic t_txoff();
      acc(1'b0, {2'd0, `QUP_REG_CTRL}, 8'h00);
      acc(1'b0, {2'd0, `QUP_REG_DATA}, 8'h5a);
      idle(BIT);
      chk("tx off pin", 8'h01, {7'h0, sout[0]});
      rdchk("tx held", {2'd0, `QUP_REG_STATUS}, 8'h02);
      acc(1'b0, {2'd0, `QUP_REG_CTRL}, `QUP_CTRL_RESET);
      idle(12 * BIT);
      rdchk("tx drained", {2'd0, `QUP_REG_STATUS}, 8'h00);
   endtask : t_txoff
   task automatic t_unmapped();
      acc(1'b0, {2'd0, 3'h5}, 8'hff);
      rdchk("unmapped", {2'd0, 3'h5}, 8'h00);
      rdchk("ctrl kept", {2'd0, `QUP_REG_CTRL}, `QUP_CTRL_RESET);
   endtask : t_unmapped
   initial begin
      rst = 1'b1;
      mode68 = 1'b1;
      cs_n = 1'b1;
      addr = 5'h00;
      wdata = 8'h00;
      rd_wr = 1'b1;
      strobe_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      idle(6);
      rst = 1'b0;
      idle(1);
      t_reset();
      t_rx();
      t_tx();
      t_loop();
      t_txoff();
      t_unmapped();
      end_of_test();
   end
endmodule : qup_pin_io_tb_top

// [sim/qup_remote_model.sv]
// remote serial party driving the four receive inputs of the block
// assumes 8N1 frames of BIT clocks per bit, changes on the falling edge
`timescale 1ns/1ps
module qup_remote_model #(
   parameter int BIT = 16
) (
   // clock and lines
   input wire logic clk_sys,
   output logic [3:0] line
);
   // --------
   // frame driver
   // --------
   // idle high from time zero, through reset as well
   initial line = 4'hf;
   // automatic so that channels may send at once
   task automatic send(input int c, input logic [7:0] d);
      logic [9:0] f;
      f = {1'b1, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         line[c] = f[i];
         repeat (BIT) @(negedge clk_sys);
      end
   endtask : send
endmodule : qup_remote_model
